// *** verilog/spi_rate_pkg.sv ***
// constants, register map and carrier types of the spi rate/status block
package spi_rate_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_BIT_RATE = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_DATA     = 8'h10;

  // status field positions
  localparam int unsigned STAT_RXF_BIT = 7;
  localparam int unsigned STAT_TXE_BIT = 5;
  localparam int unsigned STAT_FLT_BIT = 4;

  // bit_rate_select field positions and widths
  localparam int unsigned PRE_LSB  = 4;
  localparam int unsigned DIV_LSB  = 0;
  localparam int unsigned CODE_W   = 3;

  // control two field position
  localparam int unsigned FLT_EN_BIT = 4;

  // writable masks and reset values
  localparam logic [7:0] RATE_MASK  = 8'h77;
  localparam logic [7:0] CTRL2_MASK = 8'h1B;
  localparam logic [7:0] CTRL1_RST  = 8'h04;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // one byte takes sixteen clock edges
  localparam logic [3:0] LAST_EDGE  = 4'hF;
  localparam logic [3:0] EDGE_ZERO  = 4'h0;
  localparam logic [2:0] PRE_ZERO   = 3'h0;
  localparam logic [7:0] DIV_ZERO   = 8'h00;
  localparam logic [8:0] DIV_ONE    = 9'h001;

  typedef struct packed {
    logic rx_fault_irq_enable;
    logic interface_enable;
    logic transmit_irq_enable;
    logic master_select;
    logic clk_polarity;
    logic clk_phase;
    logic select_output_enable;
    logic lsb_first;
  } control_register_one_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] ofs;
  } bus_req_t;

  typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_t;

endpackage

// *** verilog/spi_rate_status.sv ***
// spi master bit-rate generator, shifter, buffers and status flags
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Function
// - prescaler divides bus clock by code plus one, codes 0..7
// - divider divides prescaler output by 2 to 256, giving master bit clock
// - prescaler fed by bus clock, feeding divider in series
// - bit_rate_select may be read or written at any time
// - unused status bits read zero; status writes do nothing
// - receive_full_flag set when a transfer completes
// - receive_full_flag clears by status read while set, then data read
// - transmit_empty_flag high when transmit buffer has room
// - transmit_empty_flag clears by status read while set, then data write
// - data write ignored unless preceded by status read seeing empty flag
// - transmit interrupt while empty flag and transmit enable are set
// - empty flag set when a byte moves from buffer to shifter
// - idle interface loads written byte, empty flag set within two cycles
// - at shift end a queued byte loads automatically, setting empty flag
// - at shift end with nothing queued, flag stays set, nothing loads
// - mode_fault_flag set when master sees slave-select input low
// - fault detection only with master, fault enable on, select output off
// - mode_fault_flag clears by status read while set, then ctrl one write
// - receive/fault interrupt while enabled and receive or fault flag set
// - disabling aborts transfer, clears receive flag, sets empty flag
// - overrun keeps old byte, drops new one, no indication
module spi_rate_status
  import spi_rate_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // serial link
  output logic             sck_o,
  output logic             mosi_o,
  input  wire logic        miso_i,
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_oe_o,
  // interrupt requests
  output logic             tx_irq_o,
  output logic             rx_fault_irq_o
);

  control_register_one_t ctrl1_ff;
  logic [7:0]            ctrl2_ff;
  logic [7:0]            rate_ff;
  bus_req_t              req_ff;
  logic                  req_vld_ff;
  logic [31:0]           hrdata_ff;
  xfer_state_t           state_ff;
  logic [2:0]            pre_cnt_ff;
  logic [7:0]            div_cnt_ff;
  logic [3:0]            edge_cnt_ff;
  logic                  sck_ff;
  logic                  sample_ff;
  logic [7:0]            shift_ff;
  logic [7:0]            txbuf_ff;
  logic [7:0]            rxbuf_ff;
  logic                  txe_ff;
  logic                  rxf_ff;
  logic                  flt_ff;
  logic                  tx_armed_ff;
  logic                  rx_armed_ff;
  logic                  flt_armed_ff;

  logic                  acc;
  logic                  rd_stat;
  logic                  rd_data;
  logic                  wr_data;
  logic                  wr_ctrl1;
  logic [7:0]            status_val;
  logic [7:0]            rd_val;
  logic [2:0]            prescale_code;
  logic [2:0]            divider_code;
  logic [7:0]            half_lim;
  logic                  pre_tick;
  logic                  half_tick;
  logic                  shifting;
  logic                  done;
  logic                  load;
  logic                  tx_accept;
  logic                  rx_clr;
  logic                  flt_detect;
  logic [7:0]            rx_byte;
  logic                  enabled;

  // ---------------- bus slave ----------------
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_ff;

  assign acc      = hsel_i && hready_i && htrans_i[1];
  assign rd_stat  = acc && !hwrite_i && (haddr_i[7:0] == OFS_STATUS);
  assign rd_data  = acc && !hwrite_i && (haddr_i[7:0] == OFS_DATA);
  // writes act in the data phase, once hwdata is on the bus
  assign wr_data  = req_vld_ff && req_ff.wr && (req_ff.ofs == OFS_DATA);
  assign wr_ctrl1 = req_vld_ff && req_ff.wr && (req_ff.ofs == OFS_CTRL_ONE);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_vld_ff <= 1'b0;
      req_ff     <= '0;
    end else begin
      req_vld_ff <= acc && hwrite_i;
      req_ff     <= '{wr: hwrite_i, ofs: haddr_i[7:0]};
    end
  end

  always_comb begin
    status_val               = BYTE_ZERO;
    status_val[STAT_RXF_BIT] = rxf_ff;
    status_val[STAT_TXE_BIT] = txe_ff;
    status_val[STAT_FLT_BIT] = flt_ff;
  end

  always_comb begin
    unique case (haddr_i[7:0])
      OFS_CTRL_ONE: rd_val = ctrl1_ff;
      OFS_CTRL_TWO: rd_val = ctrl2_ff;
      OFS_BIT_RATE: rd_val = rate_ff;
      OFS_STATUS:   rd_val = status_val;
      OFS_DATA:     rd_val = rxbuf_ff;
      default:      rd_val = BYTE_ZERO;
    endcase
  end

  // read data is captured at the address phase so it comes from a flop
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (acc && !hwrite_i) begin
      hrdata_ff <= {24'h00_0000, rd_val};
    end
  end

  // status register has no write path at all
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl1_ff <= control_register_one_t'(CTRL1_RST);
    end else if (wr_ctrl1) begin
      ctrl1_ff <= control_register_one_t'(hwdata_i[7:0]);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl2_ff <= CTRL2_RST;
    end else if (req_vld_ff && (req_ff.ofs == OFS_CTRL_TWO)) begin
      ctrl2_ff <= hwdata_i[7:0] & CTRL2_MASK;
    end
  end

  // no busy interlock: a new rate is taken even in mid-transfer
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_ff <= RATE_RST;
    end else if (req_vld_ff && (req_ff.ofs == OFS_BIT_RATE)) begin
      rate_ff <= hwdata_i[7:0] & RATE_MASK;
    end
  end

  // ---------------- bit-rate generation ----------------
  assign enabled       = ctrl1_ff.interface_enable;
  assign prescale_code = rate_ff[PRE_LSB +: CODE_W];
  assign divider_code  = rate_ff[DIV_LSB +: CODE_W];
  assign shifting      = (state_ff == XFER_SHIFT);

  // >= compares keep a shrunk code from stranding a counter
  assign pre_tick  = (pre_cnt_ff >= prescale_code);
  assign half_lim  = 8'((DIV_ONE << divider_code) - DIV_ONE);
  assign half_tick = pre_tick && (div_cnt_ff >= half_lim);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_cnt_ff <= PRE_ZERO;
    end else if (!shifting || pre_tick) begin
      pre_cnt_ff <= PRE_ZERO;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 3'h1;
    end
  end

  // divider advances only on prescaler output
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_ff <= DIV_ZERO;
    end else if (!shifting || half_tick) begin
      div_cnt_ff <= DIV_ZERO;
    end else if (pre_tick) begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end

  // ---------------- shifter ----------------
  assign done    = shifting && half_tick && (edge_cnt_ff == LAST_EDGE);
  assign rx_byte = {shift_ff[6:0], sample_ff};
  assign load    = enabled && ctrl1_ff.master_select && !txe_ff
                   && (!shifting || done);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= XFER_IDLE;
    end else if (!enabled) begin
      state_ff <= XFER_IDLE;
    end else if (load) begin
      state_ff <= XFER_SHIFT;
    end else if (done) begin
      state_ff <= XFER_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edge_cnt_ff <= EDGE_ZERO;
    end else if (!shifting || !enabled) begin
      edge_cnt_ff <= EDGE_ZERO;
    end else if (half_tick) begin
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
    end
  end

  // an abort drops the clock straight back to its idle level
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_ff <= 1'b0;
    end else if (!shifting || !enabled) begin
      sck_ff <= 1'b0;
    end else if (half_tick) begin
      sck_ff <= !sck_ff;
    end
  end

  // sample on leading edge, shift on trailing edge
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sample_ff <= 1'b0;
    end else if (shifting && half_tick && !sck_ff) begin
      sample_ff <= miso_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_ff <= BYTE_ZERO;
    end else if (load) begin
      shift_ff <= txbuf_ff;
    end else if (shifting && half_tick && sck_ff) begin
      shift_ff <= rx_byte;
    end
  end

  assign sck_o   = sck_ff ^ ctrl1_ff.clk_polarity;
  assign mosi_o  = shift_ff[7];
  assign ss_oe_o = enabled && ctrl1_ff.master_select
                   && ctrl2_ff[FLT_EN_BIT] && ctrl1_ff.select_output_enable;
  assign ss_n_o  = !shifting;

  // ---------------- transmit side ----------------
  assign tx_accept = wr_data && tx_armed_ff && txe_ff;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_armed_ff <= 1'b0;
    end else if (rd_stat && txe_ff) begin
      tx_armed_ff <= 1'b1;
    end else if (wr_data) begin
      tx_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txbuf_ff <= BYTE_ZERO;
    end else if (tx_accept) begin
      txbuf_ff <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txe_ff <= 1'b1;
    end else if (!enabled) begin
      txe_ff <= 1'b1;
    end else if (load) begin
      txe_ff <= 1'b1;
    end else if (tx_accept) begin
      txe_ff <= 1'b0;
    end
  end

  // ---------------- receive side ----------------
  assign rx_clr = rd_data && rx_armed_ff;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_armed_ff <= 1'b0;
    end else if (rd_stat && rxf_ff) begin
      rx_armed_ff <= 1'b1;
    end else if (rd_data || !enabled) begin
      rx_armed_ff <= 1'b0;
    end
  end

  // a completion in the clearing cycle wins and its byte is kept
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxf_ff <= 1'b0;
    end else if (!enabled) begin
      rxf_ff <= 1'b0;
    end else if (done && (!rxf_ff || rx_clr)) begin
      rxf_ff <= 1'b1;
    end else if (rx_clr) begin
      rxf_ff <= 1'b0;
    end
  end

  // overrun leaves the unread byte in place, with no error flag
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxbuf_ff <= BYTE_ZERO;
    end else if (enabled && done && (!rxf_ff || rx_clr)) begin
      rxbuf_ff <= rx_byte;
    end
  end

  // ---------------- mode fault ----------------
  assign flt_detect = enabled && ctrl1_ff.master_select
                      && ctrl2_ff[FLT_EN_BIT]
                      && !ctrl1_ff.select_output_enable
                      && !ss_n_i;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flt_armed_ff <= 1'b0;
    end else if (rd_stat && flt_ff) begin
      flt_armed_ff <= 1'b1;
    end else if (wr_ctrl1) begin
      flt_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flt_ff <= 1'b0;
    end else if (flt_detect) begin
      flt_ff <= 1'b1;
    end else if (wr_ctrl1 && flt_armed_ff) begin
      flt_ff <= 1'b0;
    end
  end

  // ---------------- interrupt requests ----------------
  assign tx_irq_o       = txe_ff && ctrl1_ff.transmit_irq_enable;
  assign rx_fault_irq_o = (rxf_ff || flt_ff)
                          && ctrl1_ff.rx_fault_irq_enable;

endmodule

// *** sim/spi_rate_status_assertions.sv ***
// concurrent checks on the spi rate/status block ports
`timescale 1ns/1ps
module spi_rate_status_chk
  import spi_rate_pkg::*;
(
  // clock, reset and bus
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  // serial side and requests
  input wire logic        sck_o,
  input wire logic        ss_n_o,
  input wire logic        tx_irq_o,
  input wire logic        rx_fault_irq_o
);
  logic [7:0]  ctl_ff;
  logic [7:0]  rate_ff;
  logic [10:0] gap_ff;
  logic [4:0]  edge_ff;
  logic        sck_ff;
  logic        st_ff;
  logic        wc_ff;
  logic        wr_ff;
  logic        wd_ff;
  logic        arm_ff;
  logic        take;
  logic        chg;
  logic [10:0] half;
  assign take = hsel_i && hready_i && htrans_i[1];
  assign chg  = sck_o != sck_ff;
  assign half = (11'(rate_ff[6:4]) + 11'h001) << rate_ff[2:0];
  // shadow of the writes so expectations do not lean on internals
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_ff  <= CTRL1_RST;
      rate_ff <= RATE_RST;
      {st_ff, wc_ff, wr_ff, wd_ff, arm_ff} <= 5'h00;
      sck_ff  <= 1'b0;
      gap_ff  <= 11'h000;
      edge_ff <= 5'h00;
    end else begin
      st_ff <= take && !hwrite_i && haddr_i[7:0] == OFS_STATUS;
      wc_ff <= take && hwrite_i && haddr_i[7:0] == OFS_CTRL_ONE;
      wr_ff <= take && hwrite_i && haddr_i[7:0] == OFS_BIT_RATE;
      wd_ff <= take && hwrite_i && haddr_i[7:0] == OFS_DATA;
      if (wc_ff) ctl_ff <= hwdata_i[7:0];
      if (wr_ff) rate_ff <= hwdata_i[7:0] & RATE_MASK;
      if (st_ff) arm_ff <= hrdata_o[STAT_TXE_BIT];
      else if (wd_ff) arm_ff <= 1'b0;
      sck_ff  <= sck_o;
      gap_ff  <= chg ? 11'h001 : gap_ff + 11'h001;
      edge_ff <= (ss_n_o && !chg) ? 5'h00 : edge_ff + 5'(chg);
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_armed_write;
    wd_ff && arm_ff && ss_n_o && ctl_ff[6] && ctl_ff[4];
  endsequence
  sequence s_shift_start;
    ##[1:2] !ss_n_o;
  endsequence
  AST_STAT_ZERO: assert property (st_ff |->
    hrdata_o[31:8] == 24'h00_0000 && !hrdata_o[6] && hrdata_o[3:0] == 4'h0)
    else $error("status spare bits set");
  AST_TX_IRQ_EN: assert property (tx_irq_o |-> ctl_ff[5])
    else $error("tx request while disabled");
  AST_RX_IRQ_EN: assert property (rx_fault_irq_o |-> ctl_ff[7])
    else $error("rx request while disabled");
  AST_OFF_TXE: assert property (!ctl_ff[6] && $past(!ctl_ff[6])
    && ctl_ff[5] |-> tx_irq_o) else $error("empty flag low while off");
  AST_ABORT: assert property (
    !ctl_ff[6] && $past(!ctl_ff[6]) |-> ss_n_o)
    else $error("shifting while off");
  AST_SCK_IDLE: assert property (ss_n_o && $past(ss_n_o)
    |-> sck_o == ctl_ff[3]) else $error("clock moved while idle");
  AST_HALF_BIT: assert property (
    chg && !ss_n_o && edge_ff[3:0] != 4'h0 |-> gap_ff == half)
    else $error("half bit length wrong");
  AST_BYTE_EDGES: assert property ($rose(ss_n_o) && ctl_ff[6]
    |-> (edge_ff[3:0] + 4'(chg)) == 4'h0) else $error("edge count wrong");
  AST_IDLE_LOAD: assert property (
    s_armed_write |-> s_shift_start) else $error("idle load late");
endmodule

bind spi_rate_status spi_rate_status_chk i_chk (.core_clk_i, .arst_n_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o,
  .sck_o, .ss_n_o, .tx_irq_o, .rx_fault_irq_o);

// *** sim/spi_slave_model.sv ***
// behavioural mode-0 spi slave on the far side of the link
`timescale 1ns/1ps
module spi_slave_model (
  // link pins
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       ss_n_i,
  output logic            miso_o,
  // observation
  output logic [7:0]      got_o,
  output logic [7:0]      count_o
);
  logic [7:0] tx = 8'hA5;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [3:0] bits = 4'h0;
  logic       last = 1'b0;
  initial begin
    got_o = 8'h00;
    count_o = 8'h00;
  end
  // a released line shows the inverse of its last bit, never a stale copy
  assign miso_o = ss_n_i ? ~last : sh[7];
  always @(posedge ss_n_i) last = sh[7];
  always @(negedge ss_n_i) begin
    sh = tx;
    bits = 4'h0;
  end
  always @(posedge sck_i) if (!ss_n_i) begin
    rx = {rx[6:0], mosi_i};
    bits = bits + 4'h1;
    if (bits == 4'h8) begin
      got_o = rx;
      count_o = count_o + 8'h01;
      bits = 4'h0;
      tx = ~tx;
    end
  end
  // a new byte replaces the shift after the eighth bit
  always @(negedge sck_i) if (!ss_n_i) sh = (bits == 4'h0) ? tx : sh << 1;
endmodule

// *** sim/tb.sv ***
// self-checking bench for the spi rate/status block
`timescale 1ns/1ps
module tb;
  import spi_rate_pkg::*;
  logic        core_clk_i, arst_n_i, hsel_i, hwrite_i, ext_ss_n;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]  htrans_i;
  logic        hreadyout_o, hresp_o, sck_o, mosi_o, miso_i, ss_n_i;
  logic        ss_n_o, ss_oe_o, tx_irq_o, rx_fault_irq_o;
  logic [7:0]  got, count;
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          gap;
  spi_rate_status i_dut (.core_clk_i, .arst_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .sck_o, .mosi_o, .miso_i, .ss_n_i,
    .ss_n_o, .ss_oe_o, .tx_irq_o, .rx_fault_irq_o);
  spi_slave_model i_peer (.sck_i(sck_o), .mosi_i(mosi_o), .ss_n_i(ss_n_o),
    .miso_o(miso_i), .got_o(got), .count_o(count));
  // the select pin carries our output only while the block drives it
  assign ss_n_i = ss_oe_o ? ss_n_o : ext_ss_n;
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    ck(rd, exp);
    ck(hresp_o, 1'b0);
  endtask
  task automatic t_regs();
    rchk(OFS_CTRL_ONE, 32'h0000_0004);
    rchk(OFS_BIT_RATE, 32'h0000_0000);
    bus(1'b1, OFS_CTRL_ONE, 32'h0000_0070);
    bus(1'b1, OFS_DATA, 32'h0000_0011);
    repeat (4) @(posedge core_clk_i);
    ck(ss_n_o, 1'b1);
    ck(tx_irq_o, 1'b1);
    bus(1'b1, OFS_CTRL_ONE, 32'h0000_0004);
    @(posedge core_clk_i);
    ck(tx_irq_o, 1'b0);
    bus(1'b1, OFS_STATUS, 32'h0000_00FF);
    rchk(OFS_STATUS, 32'h0000_0020);
    bus(1'b1, OFS_BIT_RATE, 32'h0000_00FF);
    rchk(OFS_BIT_RATE, 32'h0000_0077);
    bus(1'b1, 8'h1C, 32'h0000_00FF);
    rchk(8'h1C, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_xfer();
    bus(1'b1, OFS_BIT_RATE, 32'h0000_0010);
    bus(1'b1, OFS_CTRL_ONE, 32'h0000_00F0);
    rchk(OFS_STATUS, 32'h0000_0020);
    bus(1'b1, OFS_DATA, 32'h0000_003C);
    @(posedge core_clk_i);
    rchk(OFS_STATUS, 32'h0000_0020);
    bus(1'b1, OFS_DATA, 32'h0000_00C3);
    rchk(OFS_STATUS, 32'h0000_0000);
    ck(tx_irq_o, 1'b0);
    while (count !== 8'h02) @(posedge core_clk_i);
    repeat (8) @(posedge core_clk_i);
    ck(tx_irq_o, 1'b1);
    ck(rx_fault_irq_o, 1'b1);
    ck(got, 8'hC3);
    rchk(OFS_DATA, 32'h0000_00A5);
    rchk(OFS_STATUS, 32'h0000_00A0);
    rchk(OFS_DATA, 32'h0000_00A5);
    rchk(OFS_STATUS, 32'h0000_0020);
    @(posedge core_clk_i);
    ck(rx_fault_irq_o, 1'b0);
    $display("test xfer done");
  endtask
  task automatic t_disable();
    bus(1'b1, OFS_BIT_RATE, 32'h0000_0073);
    rchk(OFS_STATUS, 32'h0000_0020);
    bus(1'b1, OFS_DATA, 32'h0000_0099);
    while (sck_o !== 1'b1) @(posedge core_clk_i);
    gap = 0;
    while (sck_o === 1'b1) begin
      @(posedge core_clk_i);
      gap = gap + 1;
    end
    while (sck_o !== 1'b1) begin
      @(posedge core_clk_i);
      gap = gap + 1;
    end
    ck(gap, 32'h0000_0080);
    rchk(OFS_STATUS, 32'h0000_0020);
    bus(1'b1, OFS_DATA, 32'h0000_0055);
    @(posedge core_clk_i);
    ck(tx_irq_o, 1'b0);
    bus(1'b1, OFS_CTRL_ONE, 32'h0000_0030);
    repeat (2) @(posedge core_clk_i);
    ck(ss_n_o, 1'b1);
    ck(tx_irq_o, 1'b1);
    rchk(OFS_STATUS, 32'h0000_0020);
    $display("test disable done");
  endtask
  task automatic t_fault();
    logic [7:0] c1 [4];
    logic [7:0] c2 [4];
    logic [7:0] st [4];
    logic       oe [4];
    c1 = '{8'hD0, 8'hDA, 8'hD0, 8'hC0};
    c2 = '{8'h10, 8'h10, 8'h00, 8'h10};
    st = '{8'h30, 8'h20, 8'h20, 8'h20};
    oe = '{1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CTRL_TWO, {24'h00_0000, c2[i]});
      bus(1'b1, OFS_CTRL_ONE, {24'h00_0000, c1[i]});
      ext_ss_n <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      ck(ss_oe_o, oe[i]);
      ck(sck_o, c1[i][3]);
      ck(rx_fault_irq_o, st[i][4]);
      ext_ss_n <= 1'b1;
      rchk(OFS_STATUS, {24'h00_0000, st[i]});
      bus(1'b1, OFS_CTRL_ONE, {24'h00_0000, c1[i]});
      rchk(OFS_STATUS, 32'h0000_0020);
    end
    $display("test fault done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    arst_n_i = 1'b0;
    {hsel_i, hwrite_i, htrans_i} = 4'h0;
    haddr_i = 32'h0000_0000;
    hwdata_i = 32'h0000_0000;
    ext_ss_n = 1'b1;
    repeat (6) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_regs();
    t_xfer();
    t_disable();
    t_fault();
    summarize();
  end
endmodule
